// File: bench/asp_far_end.sv
// Remote serial device model on the line side
`timescale 1ns/1ps
`default_nettype none
module asp_far_end (
    input wire logic pclk,
    input wire logic line_from_dut,
    output logic line_to_dut
);
    int bit_cyc = 8;
    logic nine = 1'b0;
    logic [7:0] got_data;
    logic got_ninth;
    logic got_stop;
    int got_cnt = 0;
    initial line_to_dut = 1'b1;
    // Start, data lsb first, optional ninth, stop; idle high after
    task automatic send(input logic [7:0] d, input logic n9, input logic b9, input logic stp);
        logic [10:0] f;
        int nb;
        f = n9 ? {stp, b9, d, 1'b0} : {1'b1, stp, d, 1'b0};
        nb = n9 ? 11 : 10;
        @(posedge pclk);
        for (int i = 0; i < nb; i++) begin
            line_to_dut <= f[i];
            repeat (bit_cyc) @(posedge pclk);
        end
        line_to_dut <= 1'b1;
    endtask
    // Mid-bit sampling of frames sent by the port
    initial begin
        forever begin
            @(negedge line_from_dut);
            repeat (bit_cyc / 2) @(posedge pclk);
            for (int i = 0; i < 8; i++) begin
                repeat (bit_cyc) @(posedge pclk);
                got_data[i] = line_from_dut;
            end
            if (nine) begin
                repeat (bit_cyc) @(posedge pclk);
                got_ninth = line_from_dut;
            end
            repeat (bit_cyc) @(posedge pclk);
            got_stop = line_from_dut;
            got_cnt++;
        end
    end
endmodule
`default_nettype wire

// File: bench/asp_top_props.sv
// Assertion checker on the serial port top ports
`timescale 1ns/1ps
`default_nettype none
module asp_props (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic serial_out_pin,
    input wire logic irq
);
    // ========================================
    // Helpers
    logic wr_fire;
    logic rd_fire;
    logic ie_q;
    assign wr_fire = psel && penable && pready && pwrite;
    assign rd_fire = psel && penable && pready && !pwrite;
    // Shadow of the interrupt enable, taken at the edge a write lands
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ie_q <= 1'b0;
        end else if (wr_fire && paddr == asp_pkg::ADDR_INT_ENABLE) begin
            ie_q <= pwdata[0];
        end
    end
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);
    // ========================================
    // Properties
    property p_setup_ready;
        psel && !penable |=> pready;
    endproperty
    a_setup_ready: assert property (p_setup_ready) else $error("pready missing after setup");
    property p_ready_pulse;
        pready |=> !pready;
    endproperty
    a_ready_pulse: assert property (p_ready_pulse) else $error("pready longer than one cycle");
    property p_no_slverr;
        !pslverr;
    endproperty
    a_no_slverr: assert property (p_no_slverr) else $error("pslverr raised");
    property p_ctl_fixed_one;
        rd_fire && paddr == asp_pkg::ADDR_CONTROL |-> prdata[asp_pkg::CTL_UNUSED];
    endproperty
    a_ctl_fixed_one: assert property (p_ctl_fixed_one) else $error("control bit 6 reads 0");
    property p_unmapped_zero;
        rd_fire && paddr > asp_pkg::ADDR_STATUS |-> prdata == asp_pkg::RDATA_ZERO;
    endproperty
    a_unmapped_zero: assert property (p_unmapped_zero) else $error("unmapped read not zero");
    property p_irq_needs_enable;
        $rose(irq) |-> (ie_q || $past(ie_q));
    endproperty
    a_irq_needs_enable: assert property (p_irq_needs_enable) else $error("irq while disabled");
    property p_irq_held;
        $fell(irq) |-> ($past(wr_fire) || $past(wr_fire, 2));
    endproperty
    a_irq_held: assert property (p_irq_held) else $error("irq fell without a write");
    property p_tx_starts;
        wr_fire && paddr == asp_pkg::ADDR_DATA |-> ##[1:1000] !serial_out_pin;
    endproperty
    a_tx_starts: assert property (p_tx_starts) else $error("no start bit after data write");
    property p_start_low;
        $fell(serial_out_pin) |=> !serial_out_pin;
    endproperty
    a_start_low: assert property (p_start_low) else $error("start bit too short");
endmodule
bind asp_top asp_props i_props (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .serial_out_pin(serial_out_pin), .irq(irq));
`default_nettype wire

// File: bench/asp_top_tb_top.sv
// Self-checking testbench of the serial port
`timescale 1ns/1ps
`default_nettype none
module asp_top_tb_top;
    logic pclk;
    logic presetn;
    logic psel;
    logic penable;
    logic pwrite;
    logic [7:0] paddr;
    logic [31:0] pwdata;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic serial_in_pin;
    logic osc_tick;
    logic timer_ext_input;
    logic serial_out_pin;
    logic irq;
    int err_count = 0;
    int compares = 0;
    int cyc = 0;
    asp_top i_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .serial_in_pin(serial_in_pin), .osc_tick(osc_tick), .timer_ext_input(timer_ext_input),
        .serial_out_pin(serial_out_pin), .irq(irq));
    asp_far_end i_far (.pclk(pclk), .line_from_dut(serial_out_pin), .line_to_dut(serial_in_pin));
    // ========================================
    // Clock, slow sources and watchdog
    initial begin
        pclk = 1'b0;
        forever #4 pclk = ~pclk;
    end
    always @(posedge pclk) begin
        osc_tick <= ~osc_tick;
        timer_ext_input <= ~timer_ext_input;
        cyc++;
        if (cyc == 40000) begin
            err_count++;
            close_out();
        end
    end
    // ========================================
    // Shared tasks
    task automatic close_out();
        $display("compares=%0d err_count=%0d", compares, err_count);
        if (err_count == 0 && compares > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        compares++;
        if (got !== exp) begin
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
            err_count++;
        end
    endtask
    // Holds the request until pready is seen at a rising edge
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r);
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        r = prdata;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] x;
        apb(1'b1, a, d, x);
    endtask
    task automatic rd(input logic [7:0] a, output logic [31:0] r);
        apb(1'b0, a, 32'h0, r);
    endtask
    // ========================================
    // Scenarios
    task automatic t_regs();
        logic [31:0] r;
        rd(asp_pkg::ADDR_CONTROL, r);
        chk(r[7:0], asp_pkg::CTL_RESET);
        wr(8'h20, 32'hffff_ffff);
        rd(8'h20, r);
        chk(r[7:0], 8'h00);
    endtask
    // One frame per clock source, both frame widths
    task automatic t_tx();
        logic [31:0] r;
        logic [2:0] src [6];
        int dv [6];
        logic [7:0] d;
        int n;
        src = '{asp_pkg::SRC_CORE, asp_pkg::SRC_DIV4, asp_pkg::SRC_DIV12, asp_pkg::SRC_DIV48,
            asp_pkg::SRC_OSC8, asp_pkg::SRC_EXT};
        dv = '{1, 4, 12, 48, 16, 2};
        wr(asp_pkg::ADDR_INT_ENABLE, 32'h1);
        wr(asp_pkg::ADDR_BAUD_RELOAD, 32'hfc);
        for (int i = 0; i < 6; i++) begin
            d = 8'h96 ^ 8'(i * 17);
            i_far.bit_cyc = 8 * dv[i];
            i_far.nine = i[0];
            wr(asp_pkg::ADDR_TIMER_CFG, {28'h0, 1'b1, src[i]});
            wr(asp_pkg::ADDR_CONTROL, {24'h0, i[0], 3'b000, i[1], 3'b000});
            n = i_far.got_cnt;
            wr(asp_pkg::ADDR_DATA, {24'h0, d});
            wait (i_far.got_cnt != n);
            chk(i_far.got_data, d);
            if (i[0]) chk({7'h0, i_far.got_ninth}, {7'h0, i[1]});
            chk({7'h0, i_far.got_stop}, 8'h01);
            rd(asp_pkg::ADDR_CONTROL, r);
            chk({7'h0, r[asp_pkg::CTL_TX_DONE]}, 8'h01);
            chk({7'h0, irq}, 8'h01);
            wr(asp_pkg::ADDR_CONTROL, 32'h0);
            repeat (3) @(posedge pclk);
            chk({7'h0, irq}, 8'h00);
        end
    endtask
    task automatic rx_case(input logic clr, input logic [7:0] ctl, input logic [7:0] d, input logic b9,
        input logic stp, input logic ld, input logic [7:0] bx, input logic n9x);
        logic [31:0] r;
        if (clr) wr(asp_pkg::ADDR_CONTROL, {24'h0, ctl});
        i_far.send(d, ctl[7], b9, stp);
        rd(asp_pkg::ADDR_CONTROL, r);
        chk({7'h0, r[asp_pkg::CTL_RX_DONE]}, {7'h0, ld});
        if (ld) chk({7'h0, r[asp_pkg::CTL_RX_NINTH]}, {7'h0, n9x});
        rd(asp_pkg::ADDR_DATA, r);
        chk(r[7:0], bx);
    endtask
    task automatic t_rx();
        logic [31:0] r;
        i_far.bit_cyc = 8;
        i_far.nine = 1'b0;
        wr(asp_pkg::ADDR_TIMER_CFG, {28'h0, 1'b1, asp_pkg::SRC_CORE});
        rx_case(1'b1, 8'h10, 8'h81, 1'b0, 1'b1, 1'b1, 8'h81, 1'b1);
        // Second frame already shifting while the first is read
        fork
            i_far.send(8'h42, 1'b0, 1'b0, 1'b1);
            begin
                repeat (30) @(posedge pclk);
                rd(asp_pkg::ADDR_DATA, r);
                chk(r[7:0], 8'h81);
                wr(asp_pkg::ADDR_CONTROL, 32'h10);
            end
        join
        wr(asp_pkg::ADDR_DATA, 32'h3c);
        rx_case(1'b0, 8'h10, 8'h99, 1'b0, 1'b1, 1'b1, 8'h42, 1'b1);
        rx_case(1'b1, 8'h00, 8'h5a, 1'b0, 1'b1, 1'b0, 8'h42, 1'b0);
        rx_case(1'b1, 8'h30, 8'h66, 1'b0, 1'b0, 1'b0, 8'h42, 1'b0);
        rx_case(1'b1, 8'h10, 8'h7e, 1'b0, 1'b0, 1'b1, 8'h7e, 1'b0);
        rx_case(1'b1, 8'hb0, 8'hc3, 1'b0, 1'b1, 1'b0, 8'h7e, 1'b0);
        rx_case(1'b1, 8'hb0, 8'he7, 1'b1, 1'b0, 1'b1, 8'he7, 1'b1);
        rx_case(1'b1, 8'h90, 8'h18, 1'b0, 1'b1, 1'b1, 8'h18, 1'b0);
    endtask
    // ========================================
    // Main sequence
    initial begin
        presetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0;
        osc_tick = 1'b0;
        timer_ext_input = 1'b0;
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        t_regs();
        t_tx();
        t_rx();
        close_out();
    end
endmodule
`default_nettype wire

// File: hw/asp_baud_timer.sv
// Eight-bit auto-reload baud timer with clock source selection
`timescale 1ns/1ps
`default_nettype none
module asp_baud_timer (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic run,
    input wire logic [2:0] src_sel,
    input wire logic [7:0] reload,
    input wire logic osc_tick,
    input wire logic ext_tick,
    input wire logic rx_realign,
    output logic tx_ovf,
    output logic rx_ovf
);
    logic [5:0] pre_q;
    logic [3:0] div12_q;
    logic [2:0] osc_q;
    logic tick;
    logic [7:0] tx_cnt_q;
    logic [7:0] rx_cnt_q;

    // ========================================
    // Prescaler
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pre_q <= 6'h00;
            div12_q <= 4'h0;
            osc_q <= 3'h0;
        end else begin
            pre_q <= (pre_q == asp_pkg::PRESCALE_LAST) ? 6'h00 : pre_q + 6'h01;
            div12_q <= (div12_q == asp_pkg::DIV12_LAST) ? 4'h0 : div12_q + 4'h1;
            if (osc_tick) begin
                osc_q <= osc_q + 3'h1;
            end
        end
    end

    always_comb begin
        case (src_sel)
            asp_pkg::SRC_CORE: tick = 1'b1;
            asp_pkg::SRC_DIV4: tick = ((pre_q & asp_pkg::DIV4_MASK) == 6'h00);
            asp_pkg::SRC_DIV12: tick = (div12_q == 4'h0);
            asp_pkg::SRC_DIV48: tick = (pre_q == 6'h00);
            asp_pkg::SRC_OSC8: tick = osc_tick && (osc_q == asp_pkg::OSC8_LAST);
            asp_pkg::SRC_EXT: tick = ext_tick;
            default: tick = 1'b0;
        endcase
    end

    // ========================================
    // Transmit counter and hidden receive copy
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tx_cnt_q <= 8'h00;
            tx_ovf <= 1'b0;
        end else begin
            tx_ovf <= run && tick && (tx_cnt_q == asp_pkg::TIMER_TOP);
            if (run && tick) begin
                tx_cnt_q <= (tx_cnt_q == asp_pkg::TIMER_TOP) ? reload : tx_cnt_q + 8'h01;
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rx_cnt_q <= 8'h00;
            rx_ovf <= 1'b0;
        end else begin
            rx_ovf <= run && tick && !rx_realign && (rx_cnt_q == asp_pkg::TIMER_TOP);
            if (rx_realign) begin
                rx_cnt_q <= reload;
            end else if (run && tick) begin
                rx_cnt_q <= (rx_cnt_q == asp_pkg::TIMER_TOP) ? reload : rx_cnt_q + 8'h01;
            end
        end
    end
endmodule
`default_nettype wire

// File: hw/asp_top.sv
// Asynchronous serial port with baud generator, APB register slave
//
// Decided for this implementation: the APB register port and the register offsets.
`timescale 1ns/1ps
`default_nettype none
module asp_top (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic serial_in_pin,
    input wire logic osc_tick,
    input wire logic timer_ext_input,
    output logic serial_out_pin,
    output logic irq
);
    logic [7:0] ctl_q;
    logic [7:0] rx_buf_q;
    logic [7:0] reload_q;
    logic [3:0] tcfg_q;
    logic ie_q;
    logic wr;
    logic rd;
    logic tx_start_q;
    logic [7:0] tx_data_q;
    logic tx_ovf;
    logic rx_ovf;
    logic tx_out;
    logic tx_done;
    logic ext_q;
    logic ext_tick;
    logic in_q;
    logic fall;
    logic realign;
    asp_pkg::asp_rx_state_t rx_st_q;
    logic rx_half_q;
    logic [3:0] rx_idx_q;
    logic [8:0] rx_sh_q;
    logic rx_end;
    logic rx_nine;
    logic rx_load;
    logic rx_busy;
    logic sel_ctl;
    logic sel_data;
    logic sel_reload;
    logic sel_tcfg;
    logic sel_ie;

    // ========================================
    // APB slave, zero wait states
    assign wr = psel && penable && pwrite;
    assign rd = psel && !penable && !pwrite;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= asp_pkg::RDATA_ZERO;
        end else begin
            pready <= psel && !penable;
            pslverr <= 1'b0;
            if (rd) begin
                case (paddr)
                    asp_pkg::ADDR_CONTROL: prdata <= {24'h0, ctl_q};
                    asp_pkg::ADDR_DATA: prdata <= {24'h0, rx_buf_q};
                    asp_pkg::ADDR_BAUD_RELOAD: prdata <= {24'h0, reload_q};
                    asp_pkg::ADDR_TIMER_CFG: prdata <= {28'h0, tcfg_q};
                    asp_pkg::ADDR_INT_ENABLE: prdata <= {31'h0, ie_q};
                    asp_pkg::ADDR_STATUS: prdata <= {30'h0, rx_busy, tx_start_q};
                    default: prdata <= asp_pkg::RDATA_ZERO;
                endcase
            end
        end
    end

    // Pready rises in the access phase, so writes land on that edge
    logic wr_take;
    assign wr_take = wr && pready;

    // ========================================
    // Write decode, one strobe per writable register
    assign sel_ctl = wr_take && (paddr == asp_pkg::ADDR_CONTROL);
    assign sel_data = wr_take && (paddr == asp_pkg::ADDR_DATA);
    assign sel_reload = wr_take && (paddr == asp_pkg::ADDR_BAUD_RELOAD);
    assign sel_tcfg = wr_take && (paddr == asp_pkg::ADDR_TIMER_CFG);
    assign sel_ie = wr_take && (paddr == asp_pkg::ADDR_INT_ENABLE);

    // New reload reaches the counters at their next wrap, and the receive copy also at a realign
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            reload_q <= 8'h00;
        end else if (sel_reload) begin
            reload_q <= pwdata[7:0];
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tcfg_q <= 4'h0;
        end else if (sel_tcfg) begin
            tcfg_q <= pwdata[3:0];
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ie_q <= 1'b0;
        end else if (sel_ie) begin
            ie_q <= pwdata[0];
        end
    end

    // Write to data location latches the byte and starts transmission
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tx_data_q <= 8'h00;
            tx_start_q <= 1'b0;
        end else begin
            tx_start_q <= sel_data;
            if (sel_data) begin
                tx_data_q <= pwdata[7:0];
            end
        end
    end

    // ========================================
    // Control register; hardware sets beat software clears
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctl_q <= asp_pkg::CTL_RESET;
        end else begin
            if (sel_ctl) begin
                ctl_q <= pwdata[7:0];
                ctl_q[asp_pkg::CTL_UNUSED] <= 1'b1;
            end
            if (rx_load) begin
                ctl_q[asp_pkg::CTL_RX_NINTH] <= rx_nine;
                ctl_q[asp_pkg::CTL_RX_DONE] <= 1'b1;
            end
            if (tx_done) begin
                ctl_q[asp_pkg::CTL_TX_DONE] <= 1'b1;
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq <= 1'b0;
        end else begin
            irq <= ie_q && (ctl_q[asp_pkg::CTL_TX_DONE] || ctl_q[asp_pkg::CTL_RX_DONE]);
        end
    end

    // ========================================
    // Baud generation
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ext_q <= 1'b0;
        end else begin
            ext_q <= timer_ext_input;
        end
    end
    assign ext_tick = timer_ext_input && !ext_q;

    asp_baud_timer u_baud (
        .pclk(pclk),
        .presetn(presetn),
        .run(tcfg_q[asp_pkg::TCFG_RUN]),
        .src_sel(tcfg_q[asp_pkg::TCFG_SEL_MSB:0]),
        .reload(reload_q),
        .osc_tick(osc_tick),
        .ext_tick(ext_tick),
        .rx_realign(realign),
        .tx_ovf(tx_ovf),
        .rx_ovf(rx_ovf)
    );

    // ========================================
    // Transmitter
    asp_tx u_tx (
        .pclk(pclk),
        .presetn(presetn),
        .tx_ovf(tx_ovf),
        .start(tx_start_q),
        .data(tx_data_q),
        .nine_bit_mode(ctl_q[asp_pkg::CTL_FRAME_WIDTH]),
        .ninth(ctl_q[asp_pkg::CTL_TX_NINTH]),
        .serial_out(tx_out),
        .done_pulse(tx_done)
    );

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            serial_out_pin <= 1'b1;
        end else begin
            serial_out_pin <= tx_out;
        end
    end

    // ========================================
    // Receiver: edge detect, half-bit then whole-bit sampling
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            in_q <= 1'b1;
        end else begin
            in_q <= serial_in_pin;
        end
    end
    assign fall = in_q && !serial_in_pin;
    assign realign = fall && (rx_st_q == asp_pkg::ASP_RX_IDLE) && ctl_q[asp_pkg::CTL_RX_ENABLE];

    // One overflow after realign is mid start bit; then two per bit
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rx_st_q <= asp_pkg::ASP_RX_IDLE;
            rx_half_q <= 1'b0;
            rx_idx_q <= 4'h0;
            rx_sh_q <= 9'h000;
        end else begin
            case (rx_st_q)
                asp_pkg::ASP_RX_IDLE: begin
                    if (realign) begin
                        rx_st_q <= asp_pkg::ASP_RX_START;
                    end
                end
                asp_pkg::ASP_RX_START: begin
                    if (rx_ovf) begin
                        rx_half_q <= 1'b0;
                        rx_idx_q <= 4'h0;
                        // False start if line is back high
                        rx_st_q <= in_q ? asp_pkg::ASP_RX_IDLE : asp_pkg::ASP_RX_DATA;
                    end
                end
                asp_pkg::ASP_RX_DATA: begin
                    if (rx_ovf) begin
                        rx_half_q <= ~rx_half_q;
                        if (rx_half_q) begin
                            rx_sh_q <= {in_q, rx_sh_q[8:1]};
                            rx_idx_q <= rx_idx_q + 4'h1;
                            if (rx_idx_q == (ctl_q[asp_pkg::CTL_FRAME_WIDTH] ? asp_pkg::DATA_LAST_IDX : 4'h7)) begin
                                rx_st_q <= asp_pkg::ASP_RX_STOP;
                            end
                        end
                    end
                end
                asp_pkg::ASP_RX_STOP: begin
                    if (rx_ovf) begin
                        rx_half_q <= ~rx_half_q;
                        if (rx_half_q) begin
                            rx_st_q <= asp_pkg::ASP_RX_IDLE;
                        end
                    end
                end
                default: rx_st_q <= asp_pkg::ASP_RX_IDLE;
            endcase
        end
    end

    // 8-bit mode: shifter holds data in [8:1]; 9-bit: data [7:0], ninth [8]
    assign rx_end = (rx_st_q == asp_pkg::ASP_RX_STOP) && rx_ovf && rx_half_q;
    assign rx_busy = (rx_st_q != asp_pkg::ASP_RX_IDLE);
    assign rx_nine = ctl_q[asp_pkg::CTL_FRAME_WIDTH] ? rx_sh_q[8] : in_q;
    // Filter checks stop bit in 8-bit mode, ninth bit in 9-bit mode
    assign rx_load = rx_end && !ctl_q[asp_pkg::CTL_RX_DONE]
                     && (!ctl_q[asp_pkg::CTL_MULTIPROC] || rx_nine);

    // Separate holding buffer lets the next frame shift in meanwhile
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rx_buf_q <= 8'h00;
        end else if (rx_load) begin
            rx_buf_q <= ctl_q[asp_pkg::CTL_FRAME_WIDTH] ? rx_sh_q[7:0] : rx_sh_q[8:1];
        end
    end
endmodule
`default_nettype wire

// File: hw/asp_tx.sv
// Transmit shifter of the serial port
`timescale 1ns/1ps
`default_nettype none
module asp_tx (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic tx_ovf,
    input wire logic start,
    input wire logic [7:0] data,
    input wire logic nine_bit_mode,
    input wire logic ninth,
    output logic serial_out,
    output logic done_pulse
);
    logic busy_q;
    logic half_q;
    logic [10:0] shift_q;
    logic [3:0] left_q;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            busy_q <= 1'b0;
            half_q <= 1'b0;
            shift_q <= 11'h7ff;
            left_q <= 4'h0;
            serial_out <= 1'b1;
            done_pulse <= 1'b0;
        end else begin
            done_pulse <= 1'b0;
            if (start) begin
                busy_q <= 1'b1;
                // Start bit waits for the next overflow so it lasts a full bit time
                half_q <= 1'b1;
                // Start bit, data lsb first, then ninth bit or stop
                shift_q <= {1'b1, (nine_bit_mode ? ninth : 1'b1), data, 1'b0};
                left_q <= (nine_bit_mode ? asp_pkg::BITS_9BIT : asp_pkg::BITS_8BIT) + 4'h1;
            end else if (busy_q && tx_ovf) begin
                half_q <= ~half_q;
                if (half_q) begin
                    left_q <= left_q - 4'h1;
                    if (left_q == 4'h2) begin
                        done_pulse <= 1'b1;
                    end
                    if (left_q == 4'h1) begin
                        busy_q <= 1'b0;
                        serial_out <= 1'b1;
                    end else begin
                        serial_out <= shift_q[0];
                        shift_q <= {1'b1, shift_q[10:1]};
                    end
                end
            end
        end
    end
endmodule
`default_nettype wire

// File: inc/asp_pkg.sv
// Package of constants for the asynchronous serial port with baud generator
package asp_pkg;
    // ========================================
    // Register byte addresses (APB, one word each)
    localparam logic [7:0] ADDR_CONTROL = 8'h00;
    localparam logic [7:0] ADDR_DATA = 8'h04;
    localparam logic [7:0] ADDR_BAUD_RELOAD = 8'h08;
    localparam logic [7:0] ADDR_TIMER_CFG = 8'h0c;
    localparam logic [7:0] ADDR_INT_ENABLE = 8'h10;
    localparam logic [7:0] ADDR_STATUS = 8'h14;
    // ========================================
    // Control register fields
    localparam int CTL_FRAME_WIDTH = 7;
    localparam int CTL_UNUSED = 6;
    localparam int CTL_MULTIPROC = 5;
    localparam int CTL_RX_ENABLE = 4;
    localparam int CTL_TX_NINTH = 3;
    localparam int CTL_RX_NINTH = 2;
    localparam int CTL_TX_DONE = 1;
    localparam int CTL_RX_DONE = 0;
    localparam logic [7:0] CTL_RESET = 8'h40;
    // ========================================
    // Timer config fields: run bit and clock source select
    localparam int TCFG_RUN = 3;
    localparam int TCFG_SEL_MSB = 2;
    localparam logic [2:0] SRC_CORE = 3'h0;
    localparam logic [2:0] SRC_DIV4 = 3'h1;
    localparam logic [2:0] SRC_DIV12 = 3'h2;
    localparam logic [2:0] SRC_DIV48 = 3'h3;
    localparam logic [2:0] SRC_OSC8 = 3'h4;
    localparam logic [2:0] SRC_EXT = 3'h5;
    localparam logic [5:0] PRESCALE_LAST = 6'h2f;
    localparam logic [5:0] DIV4_MASK = 6'h03;
    localparam logic [3:0] DIV12_LAST = 4'hb;
    localparam logic [2:0] OSC8_LAST = 3'h7;
    // ========================================
    // Frame shape
    localparam int DATA_BITS = 8;
    localparam logic [3:0] BITS_8BIT = 4'ha;
    localparam logic [3:0] BITS_9BIT = 4'hb;
    localparam logic [3:0] DATA_LAST_IDX = 4'h8;
    localparam logic [7:0] TIMER_TOP = 8'hff;
    localparam logic [31:0] RDATA_ZERO = 32'h0000_0000;
    typedef enum {ASP_RX_IDLE, ASP_RX_START, ASP_RX_DATA, ASP_RX_STOP} asp_rx_state_t;
endpackage
